/* pkg/fga_params.svh */
// Offsets, field positions, reset values and timing counts for the fast A20 / reset block.
// Assumes a 200 MHz system clock; included by the design modules.
`ifndef FGA_PARAMS_SVH
`define FGA_PARAMS_SVH

// ----------------------------------------
// Register locations
// ----------------------------------------
`define FGA_CFG_INDEX 8'hf0
`define FGA_FAST_PORT_ADDR 8'h92
`define FGA_KBC_DATA_ADDR 8'h60
`define FGA_KBC_CMD_ADDR 8'h64

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FGA_CFG_HW_RST_BIT 0
`define FGA_CFG_HW_A20_BIT 1
`define FGA_CFG_PORT_EN_BIT 2
`define FGA_FP_RST_BIT 0
`define FGA_FP_A20_BIT 1
`define FGA_DATA_A20_BIT 1
`define FGA_DATA_RST_BIT 0

// ----------------------------------------
// Reset values, fast port read bits and commands
// ----------------------------------------
`define FGA_CFG_RESET 8'h00
`define FGA_FP_RSVD_READ 8'h24
`define FGA_CMD_WRITE_OUT 8'hd1
`define FGA_CMD_PULSE_RST 8'hfe
`define FGA_CMD_NULL 8'hff

// ----------------------------------------
// Timing
// ----------------------------------------
`define FGA_CLK_MHZ 200
`define FGA_RST_DELAY_US 14
`define FGA_RST_PULSE_US 6
`define FGA_RST_DELAY_CYC (`FGA_RST_DELAY_US * `FGA_CLK_MHZ)
`define FGA_RST_PULSE_CYC (`FGA_RST_PULSE_US * `FGA_CLK_MHZ)

`endif

/* pkg/fga_pkg.sv */
// Types shared by the fast A20 / reset block.
// Assumes the params header sits on the include path.
package fga_pkg;

   // ----------------------------------------
   // Host write carrier
   // ----------------------------------------
   typedef struct packed {
      logic cfg_wr;
      logic kbc_wr;
      logic cmd_sel;
      logic fp_wr;
      logic [7:0] data;
   } fga_host_wr_t;

   // ----------------------------------------
   // Command decode states
   // ----------------------------------------
   typedef enum logic [0:0] {
      FGA_IDLE = 1'b0,
      FGA_WAIT_DATA = 1'b1
   } fga_cmd_state_t;

   // ----------------------------------------
   // Pulse timer states
   // ----------------------------------------
   typedef enum logic [1:0] {
      FGA_PT_IDLE = 2'b00,
      FGA_PT_DELAY = 2'b01,
      FGA_PT_PULSE = 2'b10
   } fga_pulse_state_t;

endpackage

/* hw/fga_pulse_timer.sv */
// Delayed low pulse generator: a start pulse gives a delay, then an active-low pulse.
// Assumes one clock domain and the synchronised reset of the top module.
`timescale 1ns/1ps
`include "fga_params.svh"

module fga_pulse_timer #(
   parameter int DELAY_CYC = `FGA_RST_DELAY_CYC,
   parameter int PULSE_CYC = `FGA_RST_PULSE_CYC
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Control
   input wire logic start_in,
   output logic pulse_n_out
);

   localparam int CW = $clog2((DELAY_CYC > PULSE_CYC ? DELAY_CYC : PULSE_CYC) + 1);

   fga_pkg::fga_pulse_state_t state;
   fga_pkg::fga_pulse_state_t next_state;
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic count_done;

   assign count_done = (count == CW'(1));

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   // Starts while busy are ignored, so one request gives one pulse.
   always_comb begin
      next_state = state;
      next_count = count;
      case (state)
         fga_pkg::FGA_PT_IDLE: begin
            if (start_in) begin
               next_state = fga_pkg::FGA_PT_DELAY;
               next_count = CW'(DELAY_CYC);
            end
         end
         fga_pkg::FGA_PT_DELAY: begin
            next_count = count - CW'(1);
            if (count_done) begin
               next_state = fga_pkg::FGA_PT_PULSE;
               next_count = CW'(PULSE_CYC);
            end
         end
         fga_pkg::FGA_PT_PULSE: begin
            next_count = count - CW'(1);
            if (count_done) begin
               next_state = fga_pkg::FGA_PT_IDLE;
            end
         end
         default: begin
            next_state = fga_pkg::FGA_PT_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state <= fga_pkg::FGA_PT_IDLE;
         count <= '0;
         pulse_n_out <= 1'b1;
      end else begin
         state <= next_state;
         count <= next_count;
         pulse_n_out <= (next_state != fga_pkg::FGA_PT_PULSE);
      end
   end

endmodule

/* hw/fga_fast_a20_reset.sv */
// Fast A20 gate and CPU reset logic: config byte, fast control port, hardware D1/FE decode.
// Assumes host writes arrive as one-cycle strobes synchronous to core_clk_in.
`timescale 1ns/1ps
`include "fga_params.svh"

module fga_fast_a20_reset #(
   parameter int DELAY_CYC = `FGA_RST_DELAY_CYC,
   parameter int PULSE_CYC = `FGA_RST_PULSE_CYC
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   // Host writes and reads
   input wire fga_pkg::fga_host_wr_t host_wr_in,
   input wire logic cfg_rd_in,
   input wire logic fp_rd_in,
   output logic [7:0] rd_data_out,
   output logic rd_valid_out,
   // Keyboard firmware side
   input wire logic kbc_a20_gate_in,
   input wire logic kbc_reset_n_in,
   output logic input_buffer_full_flag_out,
   output logic firmware_output_full_flag_out,
   // Polarity configuration
   input wire logic a20_gate_pol_in,
   input wire logic kbd_reset_pol_in,
   // System side
   output logic alternate_a20_control_out,
   output logic alternate_cpu_reset_n_out,
   output logic a20_gate_out,
   output logic a20_gate_oe_out,
   output logic keyboard_cpu_reset_out,
   output logic keyboard_cpu_reset_oe_out
);

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_meta;
   logic rst_sync;

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   logic [7:0] a20_reset_config;
   logic fp_reset_bit;
   logic fp_a20_bit;
   wire port_en = a20_reset_config[`FGA_CFG_PORT_EN_BIT];
   wire hw_a20 = a20_reset_config[`FGA_CFG_HW_A20_BIT];
   wire hw_rst = a20_reset_config[`FGA_CFG_HW_RST_BIT];
   wire fp_wr_ok = host_wr_in.fp_wr && port_en;
   wire cmd_wr = host_wr_in.kbc_wr && host_wr_in.cmd_sel;
   wire data_wr = host_wr_in.kbc_wr && !host_wr_in.cmd_sel;
   wire is_d1 = (host_wr_in.data == `FGA_CMD_WRITE_OUT);
   wire is_fe = (host_wr_in.data == `FGA_CMD_PULSE_RST);
   wire is_ff = (host_wr_in.data == `FGA_CMD_NULL);
   wire fp_rst_rise = fp_wr_ok && host_wr_in.data[`FGA_FP_RST_BIT] && !fp_reset_bit;

   // ----------------------------------------
   // Config byte and fast port
   // ----------------------------------------
   always_ff @(posedge core_clk_in or negedge rst_sync) begin
      if (!rst_sync) begin
         a20_reset_config <= `FGA_CFG_RESET;
         fp_reset_bit <= 1'b0;
         fp_a20_bit <= 1'b0;
      end else begin
         if (host_wr_in.cfg_wr) begin
            a20_reset_config <= {5'h00, host_wr_in.data[2:0]};
         end
         if (fp_wr_ok) begin
            fp_reset_bit <= host_wr_in.data[`FGA_FP_RST_BIT];
            fp_a20_bit <= host_wr_in.data[`FGA_FP_A20_BIT];
         end
      end
   end

   // ----------------------------------------
   // Hardware D1 decode
   // ----------------------------------------
   fga_pkg::fga_cmd_state_t state;
   fga_pkg::fga_cmd_state_t next_state;
   logic hw_gate_latch;
   logic hw_reset_latch;
   logic input_buffer_full_flag;
   logic set_ibf;
   logic take_data;

   // Only D1/FE/FF commands are claimed; others belong to firmware.
   always_comb begin
      next_state = state;
      set_ibf = 1'b0;
      take_data = 1'b0;
      case (state)
         fga_pkg::FGA_IDLE: begin
            if (cmd_wr && is_d1 && hw_a20) begin
               next_state = fga_pkg::FGA_WAIT_DATA;
            end else if (data_wr) begin
               set_ibf = 1'b1;
            end else if (cmd_wr && !(is_fe && hw_rst) && !is_ff) begin
               set_ibf = 1'b1;
            end
         end
         fga_pkg::FGA_WAIT_DATA: begin
            if (data_wr) begin
               take_data = 1'b1;
               next_state = fga_pkg::FGA_IDLE;
            end else if (cmd_wr && !is_d1 && !is_ff) begin
               set_ibf = 1'b1;
               next_state = fga_pkg::FGA_IDLE;
            end
         end
         default: begin
            next_state = fga_pkg::FGA_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rst_sync) begin
      if (!rst_sync) begin
         state <= fga_pkg::FGA_IDLE;
         hw_gate_latch <= 1'b0;
         hw_reset_latch <= 1'b1;
         input_buffer_full_flag <= 1'b0;
      end else begin
         state <= next_state;
         if (take_data) begin
            hw_gate_latch <= host_wr_in.data[`FGA_DATA_A20_BIT];
            hw_reset_latch <= host_wr_in.data[`FGA_DATA_RST_BIT];
         end
         // Set wins; firmware side clears by reading, modelled as reset here
         if (set_ibf) begin
            input_buffer_full_flag <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Reset pulse timers
   // ----------------------------------------
   logic fp_pulse_n;
   logic fe_pulse_n;
   wire fe_start = cmd_wr && is_fe && hw_rst && (state == fga_pkg::FGA_IDLE);

   fga_pulse_timer #(
      .DELAY_CYC(DELAY_CYC),
      .PULSE_CYC(PULSE_CYC)
   ) u_fp_timer (
      .clk_in(core_clk_in),
      .rst_b_in(rst_sync),
      .start_in(fp_rst_rise),
      .pulse_n_out(fp_pulse_n)
   );

   fga_pulse_timer #(
      .DELAY_CYC(DELAY_CYC),
      .PULSE_CYC(PULSE_CYC)
   ) u_fe_timer (
      .clk_in(core_clk_in),
      .rst_b_in(rst_sync),
      .start_in(fe_start),
      .pulse_n_out(fe_pulse_n)
   );

   // ----------------------------------------
   // Source merge
   // ----------------------------------------
   wire kbd_src_n = hw_rst ? (fe_pulse_n & hw_reset_latch) : kbc_reset_n_in;
   wire kbd_merged_n = kbd_src_n & (port_en ? fp_pulse_n : 1'b1);
   wire gate_src = hw_a20 ? hw_gate_latch : kbc_a20_gate_in;
   wire gate_merged = gate_src | (port_en & fp_a20_bit);
   wire [7:0] fp_read = `FGA_FP_RSVD_READ | {6'h00, fp_a20_bit, fp_reset_bit};
   wire [7:0] next_rd_data = cfg_rd_in ? a20_reset_config :
                             (fp_rd_in && port_en) ? fp_read : 8'h00;

   // ----------------------------------------
   // Output registers
   // ----------------------------------------
   always_ff @(posedge core_clk_in or negedge rst_sync) begin
      if (!rst_sync) begin
         rd_data_out <= 8'h00;
         rd_valid_out <= 1'b0;
         input_buffer_full_flag_out <= 1'b0;
         firmware_output_full_flag_out <= 1'b0;
         alternate_a20_control_out <= 1'b0;
         alternate_cpu_reset_n_out <= 1'b1;
         a20_gate_out <= 1'b0;
         keyboard_cpu_reset_out <= 1'b0;
         a20_gate_oe_out <= 1'b0;
         keyboard_cpu_reset_oe_out <= 1'b0;
      end else begin
         rd_data_out <= next_rd_data;
         rd_valid_out <= cfg_rd_in | (fp_rd_in & port_en);
         input_buffer_full_flag_out <= input_buffer_full_flag | set_ibf;
         firmware_output_full_flag_out <= 1'b0;
         alternate_a20_control_out <= fp_a20_bit;
         alternate_cpu_reset_n_out <= fp_pulse_n;
         a20_gate_out <= gate_merged ^ a20_gate_pol_in;
         keyboard_cpu_reset_out <= kbd_merged_n ^ kbd_reset_pol_in;
         a20_gate_oe_out <= 1'b1;
         keyboard_cpu_reset_oe_out <= 1'b1;
      end
   end

endmodule

/* testbench/fga_chk_props.sv */
// Port checker for the fast A20 / reset block.
// Assumes bind onto the top module with its count parameters.
`timescale 1ns/1ps

module fga_chk #(
   parameter int DELAY_CYC = 10,
   parameter int PULSE_CYC = 5
) (
   // Clock, reset and host side
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   input wire fga_pkg::fga_host_wr_t host_wr_in,
   input wire logic cfg_rd_in,
   input wire logic fp_rd_in,
   input wire logic [7:0] rd_data_out,
   input wire logic rd_valid_out,
   // Outputs watched
   input wire logic firmware_output_full_flag_out,
   input wire logic alternate_a20_control_out,
   input wire logic alternate_cpu_reset_n_out,
   input wire logic a20_gate_oe_out,
   input wire logic keyboard_cpu_reset_oe_out
);
   // ------------------------------
   // Shadow of port enable and fast bit 0
   // ------------------------------
   localparam int D_LO = DELAY_CYC;
   localparam int D_HI = DELAY_CYC + 4;
   logic en;
   logic fp0;
   logic armed;
   wire set_ev = host_wr_in.fp_wr && en && host_wr_in.data[0] && !fp0;
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         en <= 1'b0;
         fp0 <= 1'b0;
         armed <= 1'b0;
      end else begin
         if (host_wr_in.cfg_wr) en <= host_wr_in.data[2];
         if (host_wr_in.fp_wr && en) fp0 <= host_wr_in.data[0];
         if (set_ev) armed <= 1'b1;
         else if ($fell(alternate_cpu_reset_n_out)) armed <= 1'b0;
      end
   end
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);
   // ------------------------------
   // Assertions
   // ------------------------------
   a_cfg_resv_zero: assert property (cfg_rd_in |=> rd_valid_out && rd_data_out[7:3] == 5'h00)
      else $error("config read shows reserved bits");
   a_fp_rd_gate: assert property (fp_rd_in |=> rd_valid_out == en
      && rd_data_out[7:2] == (en ? 6'h09 : 6'h00)) else $error("fast port read wrong");
   a_alternate_a20_control_set: assert property (host_wr_in.fp_wr && en
      |=> ##1 alternate_a20_control_out == $past(host_wr_in.data[1], 2)) else $error("alternate_a20_control");
   a_rst_outs: assert property ($rose(rst_b_in)
      |-> alternate_cpu_reset_n_out && !alternate_a20_control_out) else $error("reset levels");
   a_oe_release: assert property ($rose(rst_b_in) |-> !a20_gate_oe_out
      ##4 a20_gate_oe_out && keyboard_cpu_reset_oe_out) else $error("pins not driven");
   a_alt_rst_due: assert property (set_ev |-> ##[D_LO:D_HI] !alternate_cpu_reset_n_out)
      else $error("alt reset pulse missing");
   a_alt_rst_once: assert property ($fell(alternate_cpu_reset_n_out) |-> armed)
      else $error("alt reset pulse not armed");
   a_fw_flag_low: assert property (host_wr_in.kbc_wr |=> !firmware_output_full_flag_out [*3])
      else $error("firmware flag raised");
   c_alt_pulse: cover property ($rose(alternate_cpu_reset_n_out));
   c_fp_read: cover property (fp_rd_in && en);
   c_kbc_cmd: cover property (host_wr_in.kbc_wr && host_wr_in.cmd_sel);
endmodule

bind fga_fast_a20_reset fga_chk #(.DELAY_CYC(DELAY_CYC), .PULSE_CYC(PULSE_CYC)) chk_u (
   .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .host_wr_in(host_wr_in),
   .cfg_rd_in(cfg_rd_in), .fp_rd_in(fp_rd_in), .rd_data_out(rd_data_out),
   .rd_valid_out(rd_valid_out), .firmware_output_full_flag_out(firmware_output_full_flag_out),
   .alternate_a20_control_out(alternate_a20_control_out),
   .alternate_cpu_reset_n_out(alternate_cpu_reset_n_out), .a20_gate_oe_out(a20_gate_oe_out),
   .keyboard_cpu_reset_oe_out(keyboard_cpu_reset_oe_out));

/* testbench/fga_sys_model.sv */
// System side: CPU A20 mask and CPU reset inputs.
// Assumes the keyboard reset pin is used at its active-low setting.
`timescale 1ns/1ps

module fga_sys_model (
   // From block and controller
   input wire logic kbc_a20_gate_in,
   input wire logic alternate_a20_control_in,
   input wire logic keyboard_cpu_reset_in,
   input wire logic alternate_cpu_reset_n_in,
   // CPU inputs
   output logic cpu_a20_mask_n_out,
   output logic cpu_reset_n_out
);
   assign cpu_a20_mask_n_out = kbc_a20_gate_in | alternate_a20_control_in;
   // Either reset source wins; no glitch filter here
   assign cpu_reset_n_out = keyboard_cpu_reset_in & alternate_cpu_reset_n_in;
endmodule

/* testbench/fga_fast_a20_reset_bench.sv */
// Self-checking bench for the fast A20 / reset block.
// Assumes counts cut to 10 and 5 cycles.
`timescale 1ns/1ps

module fga_fast_a20_reset_bench;
   localparam int DLY = 10;
   localparam int PLS = 5;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   fga_pkg::fga_host_wr_t hw = '0;
   logic cfg_rd = 1'b0;
   logic fp_rd = 1'b0;
   logic fw_a20 = 1'b0;
   logic fw_rst_n = 1'b1;
   logic pa = 1'b0;
   logic pk = 1'b0;
   wire [7:0] rdd;
   wire rdv, input_buffer_full_flag, fof, actl, arst_n, a20, a20_oe, krst, krst_oe, mask_n, cpu_rst_n;
   integer err_total = 0;
   integer n_compared = 0;
   integer cyc = 0;
   integer seed = 32'h6cb313ce;
   integer m_en = 0, m_fp1 = 0, m_hwsel = 0, m_latch = 0, m_wait = 0, m_ibf = 0, r;
   always #2.5 clk = ~clk;
   fga_fast_a20_reset #(.DELAY_CYC(DLY), .PULSE_CYC(PLS)) dut_u (
      .core_clk_in(clk), .rst_b_in(rst_b), .host_wr_in(hw), .cfg_rd_in(cfg_rd),
      .fp_rd_in(fp_rd), .rd_data_out(rdd), .rd_valid_out(rdv), .kbc_a20_gate_in(fw_a20),
      .kbc_reset_n_in(fw_rst_n), .input_buffer_full_flag_out(input_buffer_full_flag),
      .firmware_output_full_flag_out(fof), .a20_gate_pol_in(pa), .kbd_reset_pol_in(pk),
      .alternate_a20_control_out(actl), .alternate_cpu_reset_n_out(arst_n),
      .a20_gate_out(a20), .a20_gate_oe_out(a20_oe), .keyboard_cpu_reset_out(krst),
      .keyboard_cpu_reset_oe_out(krst_oe));
   fga_sys_model sys_u (.kbc_a20_gate_in(fw_a20), .alternate_a20_control_in(actl),
      .keyboard_cpu_reset_in(krst), .alternate_cpu_reset_n_in(arst_n),
      .cpu_a20_mask_n_out(mask_n), .cpu_reset_n_out(cpu_rst_n));
   // ------------------------------
   // Tasks and reference model
   // ------------------------------
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         err_total = err_total + 1;
         summarize();
      end
   end
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_compared = n_compared + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Kind 0 config, 1 fast port, 2 command, 3 data
   task automatic wr(input int k, input logic [7:0] d);
      fga_pkg::fga_host_wr_t v;
      v = '0;
      v.data = d;
      v.cfg_wr = (k == 0);
      v.fp_wr = (k == 1);
      v.kbc_wr = (k >= 2);
      v.cmd_sel = (k == 2);
      @(posedge clk);
      hw <= v;
      @(posedge clk);
      hw <= '0;
      if (k == 0) begin
         m_en = d[2];
         m_hwsel = d[1];
      end
      if (k == 1 && m_en) m_fp1 = d[1];
      if (k == 3 && m_wait) m_latch = d[1];
      else if (k == 3) m_ibf = 1;
      if (k == 3) m_wait = 0;
      if (k == 2 && d == 8'hd1 && m_hwsel) m_wait = 1;
      else if (k == 2 && m_wait && d != 8'hff) begin
         m_ibf = 1;
         m_wait = 0;
      end
   endtask
   task automatic rd(input logic f, input logic [7:0] e, input logic v);
      @(posedge clk);
      cfg_rd <= !f;
      fp_rd <= f;
      @(posedge clk);
      cfg_rd <= 1'b0;
      fp_rd <= 1'b0;
      #1;
      chk("rd_valid", 8'(v), rdv);
      chk("rd_data", e, rdd);
   endtask
   task automatic look();
      repeat (3) @(posedge clk);
      #1;
      chk("a20_gate", 8'(((m_hwsel ? m_latch : fw_a20) | (m_en & m_fp1)) ^ pa), a20);
      chk("alternate_a20_control", 8'(m_fp1), actl);
      chk("in_full", 8'(m_ibf), input_buffer_full_flag);
      chk("fw_full", 8'h00, fof);
      chk("a20_mask_n", 8'(fw_a20 | m_fp1), mask_n);
   endtask
   // Watches one reset output for 39 cycles after a request
   task automatic pulse(input logic k, input logic want);
      int st;
      int wd;
      st = -1;
      wd = 0;
      for (int i = 1; i < 40; i++) begin
         @(posedge clk);
         #1;
         if ((k ? krst : arst_n) === 1'b0) begin
            if (st < 0) st = i;
            wd++;
         end
      end
      if (want) chk("rst_wait", 8'h01, 8'(st >= DLY && st <= DLY + 4));
      chk("rst_width", 8'(want), 8'(wd >= PLS && wd <= PLS + 3));
   endtask
   // ------------------------------
   // Scenarios
   // ------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk("oe_pins", 8'h01, 8'(a20_oe & krst_oe));
      chk("alt_rst_n", 8'h01, arst_n);
      rd(1'b0, 8'h00, 1'b1);
      look();
      wr(0, 8'hff);
      rd(1'b0, 8'h07, 1'b1);
      wr(0, 8'h00);
      wr(1, 8'h02);
      rd(1'b1, 8'h00, 1'b0);
      @(posedge clk);
      fw_a20 <= 1'b1;
      look();
      wr(0, 8'h07);
      for (int i = 0; i < 6; i++) begin
         r = $random(seed);
         @(posedge clk);
         fw_a20 <= r[4];
         pa <= r[5];
         pk <= r[2];
         wr(1, r[7:0] & 8'hfe);
         wr(2, 8'hd1);
         if (r[6]) wr(2, 8'hd1);
         if (r[3]) wr(2, 8'hff);
         wr(3, r[15:8] | 8'h01);
         look();
         rd(1'b1, 8'h24 | 8'(m_fp1 << 1), 1'b1);
      end
      wr(2, 8'hd1);
      wr(3, 8'h00);
      look();
      chk("kbd_rst", 8'(pk), krst);
      wr(2, 8'hd1);
      wr(3, 8'h03);
      look();
      chk("kbd_rst", 8'(!pk), krst);
      @(posedge clk);
      pk <= 1'b0;
      wr(1, 8'h01);
      pulse(1'b0, 1'b1);
      wr(1, 8'h01);
      pulse(1'b0, 1'b0);
      wr(1, 8'h00);
      wr(1, 8'h01);
      pulse(1'b1, 1'b1);
      wr(2, 8'hfe);
      pulse(1'b1, 1'b1);
      look();
      wr(0, 8'h02);
      @(posedge clk);
      fw_rst_n <= 1'b0;
      look();
      chk("fw_kbd_rst", 8'h00, krst);
      chk("cpu_rst_n", 8'h00, cpu_rst_n);
      @(posedge clk);
      fw_rst_n <= 1'b1;
      wr(0, 8'h06);
      wr(2, 8'hd1);
      wr(2, 8'haa);
      look();
      wr(1, 8'h00);
      wr(1, 8'h01);
      repeat (DLY + 4) @(posedge clk);
      rst_b <= 1'b0;
      #1;
      chk("alt_rst_n", 8'h01, arst_n);
      summarize();
   end
endmodule
